// File: acd_pkg.sv
/*
  Shared constants and carrier types for the playback/record digital
  control block: register indices, field positions, reset values, timing.
  Assumes APB byte addresses equal four times the register index.
*/
package acd_pkg;
  localparam int unsigned CLOCK_HZ = 125_000_000;
  localparam int unsigned NREG = 9;
  localparam logic [7:0] IDX_LEFT_VOL = 8'h32;
  localparam logic [7:0] IDX_RIGHT_VOL = 8'h33;
  localparam logic [7:0] IDX_FRAME_RATE = 8'h35;
  localparam logic [7:0] IDX_CLK_CTRL = 8'h36;
  localparam logic [7:0] IDX_ROLE = 8'h37;
  localparam logic [7:0] IDX_STATUS = 8'h38;
  localparam logic [7:0] IDX_MUTE = 8'h3A;
  localparam logic [7:0] IDX_MUTE_STYLE = 8'h3B;
  localparam logic [7:0] IDX_SIDETONE = 8'h3C;
  localparam logic [7:0] IDX_REC_FILT = 8'h40;
  // order of the writable register slots
  localparam logic [7:0] REG_IDX [NREG] = '{IDX_LEFT_VOL, IDX_RIGHT_VOL, IDX_FRAME_RATE,
    IDX_CLK_CTRL, IDX_ROLE, IDX_MUTE, IDX_MUTE_STYLE, IDX_SIDETONE, IDX_REC_FILT};
  localparam logic [15:0] REG_MASK [NREG] = '{16'h80FF, 16'h80FF, 16'h0FFF, 16'h0017,
    16'h0001, 16'h4000, 16'h7000, 16'h3C00, 16'h8303};
  localparam logic [15:0] REG_RESET [NREG] = '{16'h00C0, 16'h00C0, 16'h0040, 16'h0000,
    16'h0000, 16'h4000, 16'h0000, 16'h0000, 16'h8000};
  localparam int unsigned SLOT_LEFT_VOL = 0;
  localparam int unsigned SLOT_RIGHT_VOL = 1;
  localparam int unsigned SLOT_FRAME_RATE = 2;
  localparam int unsigned SLOT_CLK_CTRL = 3;
  localparam int unsigned SLOT_ROLE = 4;
  localparam int unsigned SLOT_MUTE = 5;
  localparam int unsigned SLOT_MUTE_STYLE = 6;
  localparam int unsigned SLOT_SIDETONE = 7;
  localparam int unsigned SLOT_REC_FILT = 8;
  localparam int unsigned POS_PLAY_ON = 15;
  localparam int unsigned POS_COMMIT = 8;
  localparam int unsigned POS_GEN_ON = 11;
  localparam int unsigned POS_CLK_POL = 4;
  localparam int unsigned POS_MUTE = 14;
  localparam int unsigned POS_UNSILENCE = 14;
  localparam int unsigned POS_RAMP_SPEED = 13;
  localparam int unsigned POS_STOPBAND = 12;
  localparam int unsigned POS_LEFT_ST = 12;
  localparam int unsigned POS_RIGHT_ST = 10;
  localparam int unsigned POS_DC_ON = 15;
  localparam int unsigned POS_DC_CORNER = 8;
  localparam int unsigned POS_REC_LINV = 1;
  localparam int unsigned POS_REC_RINV = 0;
  localparam logic [10:0] PHASE_MIN = 11'h008;
  localparam logic [7:0] RATE_TICKS_PER_SAMPLE = 8'hFF;
  localparam logic [4:0] RAMP_FAST_SAMPLES = 5'h01;
  localparam logic [4:0] RAMP_SLOW_SAMPLES = 5'h1F;
  localparam int unsigned DC_FRAC = 11;
  typedef struct packed {
    logic signed [15:0] left;
    logic signed [15:0] right;
  } acd_stereo_type;
endpackage

// File: acd_playback_regs.sv
/*
  Digital control of the playback/record converter path: APB register set,
  volume commit, mute ramp, rate divider, frame clock, sidetone, record
  dc block and polarity, with a playback sample FIFO.
  Assumes clock stands in for the system audio clock and that bit_clock
  arrives asynchronously from the pin.
*/
// Our own choice: the APB slave port.
// Behaviour
// - New left and right gains stay pending until a one is written to the commit bit of either.
// - The right gain is eight bits, zero is silence, one the lowest gain, each code one step up.
// - As clock master the frame clock is generated only while its generation bit is set.
// - An eleven-bit field sets bit clocks per frame phase, below eight invalid, reset sixty-four.
// - A three-bit divider divides the system clock by 1, 1.5, 2, 3, 4, 5.5 or 6; 111 reserved.
// - With the style bit clear, unmuting makes the gain jump to the programmed volumes.
// - With the style bit set, unmuting makes the gain ramp up to the programmed volumes.
// - With the speed bit clear the ramp steps at half the sample rate.
// - With the speed bit set the ramp steps at one thirty-second of the sample rate.
// - A bit selects the normal or sloping-stopband playback filter response.
// - Left sidetone select adds nothing, the left or the right record channel.
// - Right sidetone select adds nothing, the left or the right record channel.
// - The record high-pass filter runs while its bit is set, which resets set.
// - A two-bit corner picks first order 2^-11 or second order 2^-5, 2^-4, 2^-3.
// - Per-channel bits pass record samples unchanged or invert their polarity.
`timescale 1ns/10ps

module acd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign level = wr_ptr - rd_ptr;
  assign in_ready = (level != (AW + 1)'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= wr_ptr + (AW + 1)'(push);
      rd_ptr <= rd_ptr + (AW + 1)'(pop);
    end
  end
endmodule // acd_fifo

module acd_dc_block (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic step,
  input wire logic [3:0] shift,
  input wire logic signed [15:0] x,
  output logic signed [15:0] y
);
  import acd_pkg::*;
  logic signed [31:0] dc_acc;
  wire logic signed [16:0] diff = 17'(x) - 17'(dc_acc >>> DC_FRAC);
  wire logic signed [31:0] delta = (32'(diff) <<< DC_FRAC) >>> shift;
  assign y = (diff > 17'sd32767) ? 16'sh7FFF : (diff < -17'sd32768) ? 16'sh8000 : diff[15:0];
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dc_acc <= '0;
    end else if (!enable) begin
      dc_acc <= '0;
    end else if (step) begin
      dc_acc <= dc_acc + delta;
    end
  end
endmodule // acd_dc_block

module acd_playback_regs import acd_pkg::*; #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bit_clock,
  output logic frame_clock,
  output logic frame_clock_oe,
  input wire logic play_in_valid,
  output logic play_in_ready,
  input wire acd_stereo_type play_in_data,
  output logic play_out_valid,
  output acd_stereo_type play_out_data,
  input wire logic rec_in_valid,
  input wire acd_stereo_type rec_in_data,
  output logic rec_out_valid,
  output acd_stereo_type rec_out_data,
  output logic [7:0] left_playback_gain,
  output logic [7:0] right_playback_gain,
  output logic left_playback_on,
  output logic right_playback_on,
  output logic playback_stopband_shape,
  output logic playback_clock_invert,
  output logic sample_tick
);
  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 64) begin : g_bad_param
    $error("FIFO_DEPTH out of range");
  end
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  logic [1:0] rst_sync;
  wire rst_n = rst_sync[1];
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  // bus decode
  wire logic [7:0] bus_idx = paddr[9:2];
  wire logic bus_aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  wire logic bus_write = psel & penable & pwrite;
  wire logic status_hit = bus_aligned && (bus_idx == IDX_STATUS);
  logic [15:0] reg_q [NREG];
  logic [NREG-1:0] hit;
  logic [LW-1:0] fifo_level;
  logic [7:0] cur_left;
  logic [7:0] cur_right;

  for (genvar i = 0; i < NREG; i++) begin : g_reg
    assign hit[i] = bus_aligned && (bus_idx == REG_IDX[i]);
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        reg_q[i] <= REG_RESET[i];
      end else if (bus_write && hit[i]) begin
        reg_q[i] <= pwdata[15:0] & REG_MASK[i];
      end
    end
  end

  wire logic mapped = (|hit) | status_hit;
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h0000_0000;
    for (int i = 0; i < NREG; i++) begin
      if (hit[i]) begin
        next_prdata = {16'h0000, reg_q[i]};
      end
    end
    if (status_hit) begin
      next_prdata = {8'h00, 2'(0), 6'(fifo_level), cur_left, cur_right};
    end
  end
  // read data captured in the setup cycle, so the access phase answers at once
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // field views
  wire logic [15:0] lvol = reg_q[SLOT_LEFT_VOL];
  wire logic [15:0] rvol = reg_q[SLOT_RIGHT_VOL];
  wire logic [15:0] frate = reg_q[SLOT_FRAME_RATE];
  wire logic [15:0] style = reg_q[SLOT_MUTE_STYLE];
  wire logic [15:0] side = reg_q[SLOT_SIDETONE];
  wire logic [15:0] rfilt = reg_q[SLOT_REC_FILT];
  wire logic [2:0] playback_rate_divider = reg_q[SLOT_CLK_CTRL][2:0];
  wire logic playback_mute = reg_q[SLOT_MUTE][POS_MUTE];
  wire logic playback_unsilence_style = style[POS_UNSILENCE];
  wire logic playback_ramp_speed = style[POS_RAMP_SPEED];
  wire logic [1:0] left_sidetone_source = side[POS_LEFT_ST +: 2];
  wire logic [1:0] right_sidetone_source = side[POS_RIGHT_ST +: 2];
  wire logic record_dc_block_on = rfilt[POS_DC_ON];
  wire logic [1:0] record_dc_block_corner = rfilt[POS_DC_CORNER +: 2];
  assign left_playback_on = lvol[POS_PLAY_ON];
  assign right_playback_on = rvol[POS_PLAY_ON];
  assign playback_stopband_shape = style[POS_STOPBAND];
  assign playback_clock_invert = reg_q[SLOT_CLK_CTRL][POS_CLK_POL];

  // volume commit: either register's commit bit applies both pending gains
  logic [7:0] target_left;
  logic [7:0] target_right;
  wire logic commit = bus_write && (hit[SLOT_LEFT_VOL] || hit[SLOT_RIGHT_VOL])
    && pwdata[POS_COMMIT];
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      target_left <= REG_RESET[SLOT_LEFT_VOL][7:0];
      target_right <= REG_RESET[SLOT_RIGHT_VOL][7:0];
    end else if (commit) begin
      target_left <= hit[SLOT_LEFT_VOL] ? pwdata[7:0] : lvol[7:0];
      target_right <= hit[SLOT_RIGHT_VOL] ? pwdata[7:0] : rvol[7:0];
    end
  end

  // rate divider in half cycles, so 1.5 and 5.5 come out exact on average
  logic [4:0] half_div;
  always_comb begin
    unique case (playback_rate_divider)
      3'h0: half_div = 5'h02;
      3'h1: half_div = 5'h03;
      3'h2: half_div = 5'h04;
      3'h3: half_div = 5'h06;
      3'h4: half_div = 5'h08;
      3'h5: half_div = 5'h0B;
      3'h6: half_div = 5'h0C;
      3'h7: half_div = 5'h00;
    endcase
  end
  logic [4:0] rate_acc;
  logic [7:0] rate_count;
  wire logic [4:0] rate_sum = rate_acc + 5'h02;
  wire logic rate_tick = (half_div != 5'h00) && (rate_sum >= half_div);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rate_acc <= 5'h00;
      rate_count <= 8'h00;
    end else if (half_div == 5'h00) begin
      rate_acc <= 5'h00;
    end else begin
      rate_acc <= rate_tick ? rate_sum - half_div : rate_sum;
      if (rate_tick) begin
        rate_count <= (rate_count == RATE_TICKS_PER_SAMPLE) ? 8'h00 : rate_count + 8'h01;
      end
    end
  end
  assign sample_tick = rate_tick && (rate_count == RATE_TICKS_PER_SAMPLE);

  // mute and gain ramp
  logic [4:0] ramp_count;
  wire logic [4:0] ramp_last = playback_ramp_speed ? RAMP_SLOW_SAMPLES : RAMP_FAST_SAMPLES;
  wire logic ramp_tick = sample_tick && (ramp_count >= ramp_last);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ramp_count <= 5'h00;
    end else if (sample_tick) begin
      ramp_count <= ramp_tick ? 5'h00 : ramp_count + 5'h01;
    end
  end
  function automatic logic [7:0] step_to(input logic [7:0] cur, input logic [7:0] tgt);
    step_to = (cur < tgt) ? cur + 8'h01 : (cur > tgt) ? cur - 8'h01 : cur;
  endfunction
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cur_left <= 8'h00;
      cur_right <= 8'h00;
    end else if (playback_mute) begin
      cur_left <= 8'h00;
      cur_right <= 8'h00;
    end else if (!playback_unsilence_style) begin
      cur_left <= target_left;
      cur_right <= target_right;
    end else if (ramp_tick) begin
      cur_left <= step_to(cur_left, target_left);
      cur_right <= step_to(cur_right, target_right);
    end
  end
  assign left_playback_gain = cur_left;
  assign right_playback_gain = cur_right;

  // frame clock from the bit clock pin
  logic [2:0] bc_sync;
  logic bc_level;
  logic [10:0] phase_count;
  wire logic bc_agree = (bc_sync[1] == bc_sync[2]);
  wire logic bc_rise = bc_agree && bc_sync[2] && !bc_level;
  wire logic clock_master = reg_q[SLOT_ROLE][0];
  wire logic gen_on = clock_master && frate[POS_GEN_ON];
  wire logic [10:0] phase_field = frate[10:0];
  // invalid short phases are clamped rather than run too fast
  wire logic [10:0] phase_len = (phase_field < PHASE_MIN) ? PHASE_MIN : phase_field;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bc_sync <= 3'h0;
      bc_level <= 1'b0;
    end else begin
      bc_sync <= {bc_sync[1:0], bit_clock};
      if (bc_agree) begin
        bc_level <= bc_sync[2];
      end
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_count <= 11'h000;
      frame_clock <= 1'b0;
    end else if (!gen_on) begin
      phase_count <= 11'h000;
      frame_clock <= 1'b0;
    end else if (bc_rise) begin
      if (phase_count == phase_len - 11'h001) begin
        phase_count <= 11'h000;
        frame_clock <= ~frame_clock;
      end else begin
        phase_count <= phase_count + 11'h001;
      end
    end
  end
  assign frame_clock_oe = gen_on;

  // record path: polarity then dc block
  function automatic logic signed [15:0] neg_sat(input logic signed [15:0] v);
    neg_sat = (v == 16'sh8000) ? 16'sh7FFF : -v;
  endfunction
  wire logic signed [15:0] rec_l = rfilt[POS_REC_LINV] ? neg_sat(rec_in_data.left)
    : rec_in_data.left;
  wire logic signed [15:0] rec_r = rfilt[POS_REC_RINV] ? neg_sat(rec_in_data.right)
    : rec_in_data.right;
  logic [3:0] dc_shift;
  always_comb begin
    unique case (record_dc_block_corner)
      2'h0: dc_shift = 4'hB;
      2'h1: dc_shift = 4'h5;
      2'h2: dc_shift = 4'h4;
      2'h3: dc_shift = 4'h3;
    endcase
  end
  wire logic second_order = (record_dc_block_corner != 2'h0);
  logic signed [15:0] st_in [4];
  logic signed [15:0] st_out [4];
  assign st_in[0] = rec_l;
  assign st_in[1] = rec_r;
  assign st_in[2] = st_out[0];
  assign st_in[3] = st_out[1];
  for (genvar s = 0; s < 4; s++) begin : g_dc
    acd_dc_block u_dc (
      .clock(clock),
      .reset_n(rst_n),
      .enable(record_dc_block_on && (s < 2 || second_order)),
      .step(rec_in_valid),
      .shift(dc_shift),
      .x(st_in[s]),
      .y(st_out[s])
    );
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rec_out_valid <= 1'b0;
      rec_out_data <= '0;
    end else begin
      rec_out_valid <= rec_in_valid;
      if (rec_in_valid) begin
        if (!record_dc_block_on) begin
          rec_out_data <= '{left: rec_l, right: rec_r};
        end else if (second_order) begin
          rec_out_data <= '{left: st_out[2], right: st_out[3]};
        end else begin
          rec_out_data <= '{left: st_out[0], right: st_out[1]};
        end
      end
    end
  end

  // playback path: fifo drained one frame per sample tick
  acd_stereo_type fifo_data;
  logic fifo_valid;
  acd_fifo #(.WIDTH($bits(acd_stereo_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .reset_n(rst_n),
    .in_valid(play_in_valid),
    .in_ready(play_in_ready),
    .in_data(play_in_data),
    .out_valid(fifo_valid),
    .out_ready(sample_tick),
    .out_data(fifo_data),
    .level(fifo_level)
  );
  function automatic logic signed [15:0] mix(input logic signed [15:0] a,
      input logic [1:0] src, input acd_stereo_type rec);
    logic signed [16:0] sum;
    sum = 17'(a);
    if (src == 2'h1) begin
      sum = 17'(a) + 17'(rec.left);
    end else if (src == 2'h2) begin
      sum = 17'(a) + 17'(rec.right);
    end
    mix = (sum > 17'sd32767) ? 16'sh7FFF : (sum < -17'sd32768) ? 16'sh8000 : sum[15:0];
  endfunction
  wire logic signed [15:0] mix_l = mix(fifo_data.left, left_sidetone_source, rec_out_data);
  wire logic signed [15:0] mix_r = mix(fifo_data.right, right_sidetone_source, rec_out_data);
  wire logic emit = sample_tick && fifo_valid;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      play_out_valid <= 1'b0;
      play_out_data <= '0;
    end else begin
      play_out_valid <= emit;
      if (emit) begin
        play_out_data.left <= (!left_playback_on || cur_left == 8'h00) ? 16'sh0000 : mix_l;
        play_out_data.right <= (!right_playback_on || cur_right == 8'h00)
          ? 16'sh0000 : mix_r;
      end
    end
  end
endmodule // acd_playback_regs

// File: acd_playback_regs_assertions.sv
/*
  Concurrent checks on the ports of acd_playback_regs.
  Assumes it is bound to that module and sees only its ports.
*/
`timescale 1ns/10ps
module acd_playback_regs_assertions import acd_pkg::*; (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic frame_clock,
  input wire logic frame_clock_oe,
  input wire logic rec_in_valid,
  input wire logic rec_out_valid,
  input wire logic play_out_valid,
  input wire logic [7:0] left_playback_gain,
  input wire logic [7:0] right_playback_gain,
  input wire logic right_playback_on,
  input wire logic playback_stopband_shape,
  input wire logic sample_tick
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_wr(logic [7:0] idx);
    psel && penable && pwrite && paddr == {2'h0, idx, 2'h0};
  endsequence
  property p_mute_zero;
    s_wr(IDX_MUTE) ##0 pwdata[POS_MUTE] |-> ##[1:2] (left_playback_gain == 8'h00 &&
      right_playback_gain == 8'h00);
  endproperty
  a_mute_zero: assert property (p_mute_zero) else $error("gain not zero after mute");
  property p_right_on;
    s_wr(IDX_RIGHT_VOL) |=> right_playback_on == $past(pwdata[POS_PLAY_ON]);
  endproperty
  a_right_on: assert property (p_right_on) else $error("right enable mismatch");
  property p_stopband;
    s_wr(IDX_MUTE_STYLE) |=> playback_stopband_shape == $past(pwdata[POS_STOPBAND]);
  endproperty
  a_stopband: assert property (p_stopband) else $error("filter shape mismatch");
  property p_gen_off;
    s_wr(IDX_FRAME_RATE) ##0 !pwdata[POS_GEN_ON] |=> !frame_clock_oe;
  endproperty
  a_gen_off: assert property (p_gen_off) else $error("frame clock still driven");
  property p_idle_low;
    (!frame_clock_oe) [*2] |-> !frame_clock;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("frame clock moves while off");
  property p_rec_pair;
    rec_out_valid == $past(rec_in_valid);
  endproperty
  a_rec_pair: assert property (p_rec_pair) else $error("record output timing");
  property p_tick_pulse;
    sample_tick |=> !sample_tick;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("sample tick too long");
  property p_out_after_tick;
    play_out_valid |-> $past(sample_tick);
  endproperty
  a_out_after_tick: assert property (p_out_after_tick) else $error("output without tick");
  property p_unaligned;
    psel && penable && paddr[1:0] != 2'h0 |-> pslverr;
  endproperty
  a_unaligned: assert property (p_unaligned) else $error("unaligned access accepted");
endmodule // acd_playback_regs_assertions

// File: acd_playback_regs_tb.sv
/*
  Self-checking bench for acd_playback_regs: APB registers, commit, mute
  ramp, divider, frame clock, record path and playback FIFO.
  Assumes the checker module is compiled first.
*/
`timescale 1ns/10ps
module acd_playback_regs_tb import acd_pkg::*;;
  logic clock, reset_n, psel, penable, pwrite, pready, pslverr, bit_clock, frame_clock;
  logic frame_clock_oe, play_in_valid, play_in_ready, play_out_valid, rec_in_valid;
  logic rec_out_valid, left_playback_on, right_playback_on, playback_stopband_shape;
  logic playback_clock_invert, sample_tick;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] left_playback_gain, right_playback_gain, ticks, t0;
  acd_stereo_type play_in_data, play_out_data, rec_in_data, rec_out_data;
  logic [31:0] rd_q[$], rec_q[$], out_q[$];
  logic [31:0] per [7] = '{32'h100, 32'h180, 32'h200, 32'h300, 32'h400, 32'h580, 32'h600};
  int failures, n_compared, seed, n, bcnt;
  acd_playback_regs dut (.clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .bit_clock, .frame_clock, .frame_clock_oe, .play_in_valid,
    .play_in_ready, .play_in_data, .play_out_valid, .play_out_data, .rec_in_valid,
    .rec_in_data, .rec_out_valid, .rec_out_data, .left_playback_gain, .right_playback_gain,
    .left_playback_on, .right_playback_on, .playback_stopband_shape,
    .playback_clock_invert, .sample_tick);
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task complete_run;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    check({31'h0, pslverr}, {31'h0, err});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task wr(input logic [7:0] idx, input logic [31:0] d);
    apb({2'h0, idx, 2'h0}, 1'b1, d, 1'b0);
    repeat (2) @(posedge clock);
  endtask
  task rd(input logic [7:0] idx, input logic [31:0] e);
    rd_q.push_back(e);
    apb({2'h0, idx, 2'h0}, 1'b0, 32'h0, 1'b0);
  endtask
  function automatic logic [7:0] pick(input int w);
    return w == 0 ? ticks : w == 1 ? right_playback_gain : {7'h00, frame_clock};
  endfunction
  // cycles between the next two changes of the picked value
  task span(input int w, output int c);
    logic [7:0] v;
    v = pick(w);
    while (pick(w) == v) @(posedge clock);
    v = pick(w);
    c = 0;
    while (pick(w) == v) begin
      @(posedge clock);
      c++;
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // slow bit clock, eight system clocks a period; results checked in order
  always @(posedge clock) begin
    bcnt <= bcnt + 1;
    bit_clock <= bcnt[2];
    if (sample_tick === 1'b1) ticks <= ticks + 8'h01;
    if (psel && penable && pready && !pwrite) check(prdata, rd_q.pop_front());
    if (rec_out_valid) check(rec_out_data, rec_q.pop_front());
    if (play_out_valid) check(play_out_data, out_q.pop_front());
  end
  initial begin
    repeat (80000) @(posedge clock);
    failures++;
    complete_run;
  end
  initial begin
    {reset_n, psel, penable, pwrite, paddr, pwdata, bit_clock} = '0;
    {play_in_valid, rec_in_valid, play_in_data, rec_in_data} = '0;
    {failures, n_compared, bcnt, ticks} = '0;
    seed = 32'hC305;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    check({24'h0, right_playback_gain}, 32'h0);
    for (int i = 0; i < NREG; i++) rd(REG_IDX[i], {16'h0, REG_RESET[i]});
    for (int i = 0; i < NREG; i++) begin
      logic [31:0] d;
      d = $random(seed);
      wr(REG_IDX[i], d);
      if (i == SLOT_LEFT_VOL) check({31'h0, left_playback_on}, {31'h0, d[POS_PLAY_ON]});
      if (i == SLOT_CLK_CTRL) check({31'h0, playback_clock_invert}, {31'h0, d[POS_CLK_POL]});
      rd(REG_IDX[i], {16'h0, d[15:0] & REG_MASK[i]});
      wr(REG_IDX[i], {16'h0, REG_RESET[i]});
    end
    rd_q.push_back(32'h0);
    apb(12'hFFC, 1'b0, 32'h0, 1'b1);
    apb(12'h0CD, 1'b1, 32'hFFFF, 1'b1);
    rd(IDX_RIGHT_VOL, 32'hC0);
    wr(IDX_LEFT_VOL, 32'h1C0);
    wr(IDX_MUTE, 32'h0);
    check({24'h0, right_playback_gain}, 32'hC0);
    wr(IDX_RIGHT_VOL, 32'h8055);
    check({24'h0, right_playback_gain}, 32'hC0);
    check({31'h0, right_playback_on}, 32'h1);
    wr(IDX_LEFT_VOL, 32'h133);
    check({16'h0, left_playback_gain, right_playback_gain}, 32'h3355);
    wr(IDX_RIGHT_VOL, 32'h8100);
    check({24'h0, right_playback_gain}, 32'h0);
    wr(IDX_RIGHT_VOL, 32'h8104);
    for (int s = 0; s < 2; s++) begin
      wr(IDX_MUTE, 32'h4000);
      check({24'h0, right_playback_gain}, 32'h0);
      wr(IDX_MUTE_STYLE, s ? 32'h6000 : 32'h4000);
      wr(IDX_MUTE, 32'h0);
      span(1, n);
      check(n, s ? 32'h2000 : 32'h200);
    end
    foreach (per[c]) begin
      wr(IDX_CLK_CTRL, c);
      span(0, n);
      span(0, n);
      check(n, per[c]);
    end
    // reserved code stops the sample rate, which also parks the FIFO
    wr(IDX_CLK_CTRL, 32'h7);
    t0 = ticks;
    repeat (2000) @(posedge clock);
    check({24'h0, ticks}, {24'h0, t0});
    n = 0;
    play_in_valid <= 1'b1;
    repeat (20) begin
      play_in_data <= $random(seed);
      @(posedge clock);
      if (play_in_ready) begin
        n++;
        out_q.push_back({16'h0, play_in_data.right});
      end
    end
    check(n, 32'h10);
    check({31'h0, play_in_ready}, 32'h0);
    play_in_valid <= 1'b0;
    wr(IDX_CLK_CTRL, 32'h0);
    repeat (4700) @(posedge clock);
    check({31'h0, play_in_ready}, 32'h1);
    check(out_q.size(), 32'h0);
    for (int k = 0; k < 4; k++) begin
      logic [15:0] l, r;
      wr(IDX_REC_FILT, k);
      l = $random(seed) & 16'h7FFF;
      r = $random(seed) & 16'h7FFF;
      rec_q.push_back({k[1] ? -l : l, k[0] ? -r : r});
      rec_in_data <= {l, r};
      rec_in_valid <= 1'b1;
      @(posedge clock);
      rec_in_valid <= 1'b0;
      repeat (3) @(posedge clock);
    end
    wr(IDX_ROLE, 32'h1);
    wr(IDX_FRAME_RATE, 32'h805);
    span(2, n);
    span(2, n);
    check(n, 32'h40);
    wr(IDX_FRAME_RATE, 32'h810);
    span(2, n);
    span(2, n);
    check(n, 32'h80);
    check({31'h0, frame_clock_oe}, 32'h1);
    wr(IDX_FRAME_RATE, 32'h10);
    check({30'h0, frame_clock_oe, frame_clock}, 32'h0);
    complete_run;
  end
endmodule // acd_playback_regs_tb
bind acd_playback_regs acd_playback_regs_assertions chk (.clock, .reset_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pslverr, .frame_clock, .frame_clock_oe, .rec_in_valid,
  .rec_out_valid, .play_out_valid, .left_playback_gain, .right_playback_gain,
  .right_playback_on, .playback_stopband_shape, .sample_tick);
